//--- rtl/aatd_cfg_if.sv
`timescale 1ns/10ps
interface aatd_cfg_if;
    import aatd_pkg::*;
    logic alm_en;
    logic [DW-1:0] hh_thr;
    logic [DW-1:0] h_thr;
    logic [DW-1:0] l_thr;
    logic [DW-1:0] ll_thr;
    logic [DBW-1:0] db_out;
    logic [DBW-1:0] db_in;
    logic tach_en;
    logic trig_rise;
    logic [LVW-1:0] off_lvl;
    logic [LVW-1:0] on_lvl;
    modport src (output alm_en, hh_thr, h_thr, l_thr, ll_thr, db_out,
        db_in, tach_en, trig_rise, off_lvl, on_lvl);
    modport eval (input alm_en, hh_thr, h_thr, l_thr, ll_thr, db_out,
        db_in, tach_en, trig_rise, off_lvl, on_lvl);
endinterface

//--- rtl/aatd_chan.sv
`timescale 1ns/10ps
module aatd_chan (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    aatd_cfg_if.eval cfg,
    input wire logic [aatd_pkg::DW-1:0] reading_i,
    input wire logic [aatd_pkg::VW-1:0] volt_i,
    output logic [3:0] alarm_o,
    output logic lvl_o,
    output logic pulse_o
);
    import aatd_pkg::*;

    logic hh_r, h_r, l_r, ll_r, raw_r, lvl_r, pulse_r;
    wire logic signed [16:0] rd_x = $signed({reading_i[15], reading_i});
    wire logic signed [16:0] hh_x = $signed({cfg.hh_thr[15], cfg.hh_thr});
    wire logic signed [16:0] h_x = $signed({cfg.h_thr[15], cfg.h_thr});
    wire logic signed [16:0] l_x = $signed({cfg.l_thr[15], cfg.l_thr});
    wire logic signed [16:0] ll_x = $signed({cfg.ll_thr[15], cfg.ll_thr});
    wire logic signed [16:0] dbo_x = $signed({2'b00, cfg.db_out});
    wire logic signed [16:0] dbi_x = $signed({2'b00, cfg.db_in});
    wire logic hh_set = rd_x >= hh_x;
    wire logic h_set = rd_x >= h_x;
    wire logic l_set = rd_x <= l_x;
    wire logic ll_set = rd_x <= ll_x;
    wire logic hh_keep = rd_x >= hh_x - dbo_x;
    wire logic ll_keep = rd_x <= ll_x + dbo_x;
    wire logic h_keep = rd_x >= h_x - dbi_x;
    wire logic l_keep = rd_x <= l_x + dbi_x;
    wire logic hh_nxt = cfg.alm_en & (hh_set | (hh_r & hh_keep));
    wire logic ll_nxt = cfg.alm_en & (ll_set | (ll_r & ll_keep));
    wire logic h_nxt = h_set | (h_r & h_keep);
    wire logic l_nxt = l_set | (l_r & l_keep);
    wire logic off_hit = volt_i <= {3'h0, cfg.off_lvl};
    wire logic on_hit = volt_i >= {3'h0, cfg.on_lvl};
    wire logic raw_nxt = !cfg.tach_en ? 1'b1 :
        off_hit ? 1'b0 : on_hit ? 1'b1 : raw_r;
    wire logic lvl_nxt = cfg.tach_en ? (raw_nxt ^ cfg.trig_rise) : 1'b1;
    wire logic pulse_nxt = cfg.tach_en & lvl_r & ~lvl_nxt;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {hh_r, h_r, l_r, ll_r} <= 4'h0;
            raw_r <= 1'b1;
            lvl_r <= 1'b1;
            pulse_r <= 1'b0;
        end else begin
            {hh_r, h_r, l_r, ll_r} <= {hh_nxt, h_nxt, l_nxt, ll_nxt};
            raw_r <= raw_nxt;
            lvl_r <= lvl_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign alarm_o = {hh_r, h_r, l_r, ll_r};
    assign lvl_o = lvl_r;
    assign pulse_o = pulse_r;

    hh_gate_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg.alm_en |=> !hh_r && !ll_r)
        else $error("outer alarm active while disabled");
    hh_set_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg.alm_en && rd_x >= hh_x |=> hh_r)
        else $error("high-high alarm missed crossing");
    hh_band_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg.alm_en && hh_r && rd_x >= hh_x - dbo_x |=> hh_r)
        else $error("high-high cleared inside deadband");
    lo_band_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        l_r && rd_x <= l_x + dbi_x |=> l_r)
        else $error("low alarm cleared inside deadband");
    lo_clear_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_x > l_x + dbi_x |=> !l_r)
        else $error("low alarm kept outside deadband");
    tach_off_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg.tach_en && volt_i <= {3'h0, cfg.off_lvl} |=> !raw_r)
        else $error("tach not off at off level");
    tach_on_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg.tach_en && !off_hit && on_hit |=> raw_r)
        else $error("tach not on at on level");
    tach_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg.tach_en && !off_hit && !on_hit |=> raw_r == $past(raw_r))
        else $error("tach state moved between levels");
    trig_pol_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg.tach_en |=> lvl_r == (raw_r ^ $past(cfg.trig_rise)))
        else $error("tach level polarity wrong");
endmodule

//--- rtl/aatd_pkg.sv
package aatd_pkg;
    localparam int NCH = 4;
    localparam int NPAIR = 2;
    localparam int DW = 16;
    localparam int DBW = 15;
    localparam int LVW = 5;
    localparam int VW = 8;
    // Configuration field selects
    localparam logic [3:0] FLD_ALM_EN = 4'h0;
    localparam logic [3:0] FLD_HH_THR = 4'h1;
    localparam logic [3:0] FLD_H_THR = 4'h2;
    localparam logic [3:0] FLD_L_THR = 4'h3;
    localparam logic [3:0] FLD_LL_THR = 4'h4;
    localparam logic [3:0] FLD_DB_OUT = 4'h5;
    localparam logic [3:0] FLD_DB_IN = 4'h6;
    localparam logic [3:0] FLD_TACH_EN = 4'h7;
    localparam logic [3:0] FLD_TRIG = 4'h8;
    localparam logic [3:0] FLD_OFF_LVL = 4'h9;
    localparam logic [3:0] FLD_ON_LVL = 4'ha;
    localparam logic [3:0] FLD_DUAL_EN = 4'hb;
    localparam logic [3:0] FLD_HI_ENG = 4'hc;
    // Alarm bit positions
    localparam int ALM_HH = 3;
    localparam int ALM_H = 2;
    localparam int ALM_L = 1;
    localparam int ALM_LL = 0;
    // Reset defaults; DEF_HI_ENG_TACH is loaded on a tach enable write, not at reset
    localparam logic [15:0] DEF_HIGH_THR = 16'h7fff;
    localparam logic [15:0] DEF_LOW_THR = 16'h0000;
    localparam logic [14:0] DEF_DB = 15'h0000;
    localparam logic [4:0] DEF_OFF_LVL = 5'h05;
    localparam logic [4:0] DEF_ON_LVL = 5'h0b;
    localparam logic [15:0] DEF_HI_ENG = 16'h2710;
    localparam logic [15:0] DEF_HI_ENG_TACH = 16'h03e8;
endpackage

//--- rtl/aatd_top.sv
// Functional notes
// - High-high and low-low alarms act only when enabled; off by default.
// - Thresholds signed 16-bit; high pair default 32767, low pair zero.
// - Separate deadband, default zero, for high-high and low-low alarms.
// - Independent deadband, default zero, for high and low alarms.
// - Enabled dual-low detection faults when both pair inputs are low.
// - Dual-low setting shared by channels 0/1 and by channels 2/3.
// - Tach input is off at or below off level, 0..31 V, default 5.
// - Tach input is on at or above on level, default 11 V.
// - Tach mode makes high engineering scaling default 1000.
`timescale 1ns/10ps
module aatd_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_ch_i,
    input wire logic [3:0] cfg_sel_i,
    input wire logic [aatd_pkg::DW-1:0] cfg_data_i,
    input wire logic [3:0][aatd_pkg::DW-1:0] reading_i,
    input wire logic [3:0][aatd_pkg::VW-1:0] tach_volt_i,
    output logic [3:0] alarm_hh_o,
    output logic [3:0] alarm_h_o,
    output logic [3:0] alarm_l_o,
    output logic [3:0] alarm_ll_o,
    output logic [3:0] tach_lvl_o,
    output logic [3:0] tach_pulse_o,
    output logic [1:0] pair_fault_o,
    output logic [3:0][aatd_pkg::DW-1:0] hi_eng_o
);
    import aatd_pkg::*;

    logic rst_meta_r, rst_sync_r;
    logic [NCH-1:0] alm_en_r, tach_en_r, trig_r;
    logic [DW-1:0] hh_r [NCH];
    logic [DW-1:0] h_r [NCH];
    logic [DW-1:0] l_r [NCH];
    logic [DW-1:0] ll_r [NCH];
    logic [DBW-1:0] dbo_r [NCH];
    logic [DBW-1:0] dbi_r [NCH];
    logic [LVW-1:0] off_r [NCH];
    logic [LVW-1:0] on_r [NCH];
    logic [DW-1:0] hi_eng_r [NCH];
    logic [NPAIR-1:0] dual_en_r, fault_r;
    logic [3:0] alarm_w [NCH];
    logic [NCH-1:0] lvl_w, pulse_w;

    // Reset released through two flops to avoid metastable release
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire logic [DBW-1:0] wr_db = cfg_data_i[DBW-1:0];
    wire logic [LVW-1:0] wr_lvl = cfg_data_i[LVW-1:0];
    wire logic wr_bit = cfg_data_i[0];
    wire logic [DW-1:0] wr_scale = wr_bit ? DEF_HI_ENG_TACH : DEF_HI_ENG;
    wire logic pair_sel = cfg_ch_i[1];

    always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            alm_en_r <= '0;
            tach_en_r <= '0;
            trig_r <= '0;
            dual_en_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                hh_r[i] <= DEF_HIGH_THR;
                h_r[i] <= DEF_HIGH_THR;
                l_r[i] <= DEF_LOW_THR;
                ll_r[i] <= DEF_LOW_THR;
                dbo_r[i] <= DEF_DB;
                dbi_r[i] <= DEF_DB;
                off_r[i] <= DEF_OFF_LVL;
                on_r[i] <= DEF_ON_LVL;
                hi_eng_r[i] <= DEF_HI_ENG;
            end
        end else if (cfg_wr_i) begin
            unique case (cfg_sel_i)
                FLD_ALM_EN: alm_en_r[cfg_ch_i] <= wr_bit;
                FLD_HH_THR: hh_r[cfg_ch_i] <= cfg_data_i;
                FLD_H_THR: h_r[cfg_ch_i] <= cfg_data_i;
                FLD_L_THR: l_r[cfg_ch_i] <= cfg_data_i;
                FLD_LL_THR: ll_r[cfg_ch_i] <= cfg_data_i;
                FLD_DB_OUT: dbo_r[cfg_ch_i] <= wr_db;
                FLD_DB_IN: dbi_r[cfg_ch_i] <= wr_db;
                FLD_TACH_EN: begin
                    tach_en_r[cfg_ch_i] <= wr_bit;
                    hi_eng_r[cfg_ch_i] <= wr_scale;
                end
                FLD_TRIG: trig_r[cfg_ch_i] <= wr_bit;
                FLD_OFF_LVL: off_r[cfg_ch_i] <= wr_lvl;
                FLD_ON_LVL: on_r[cfg_ch_i] <= wr_lvl;
                FLD_DUAL_EN: dual_en_r[pair_sel] <= wr_bit;
                FLD_HI_ENG: hi_eng_r[cfg_ch_i] <= cfg_data_i;
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            aatd_cfg_if cif ();
            assign cif.alm_en = alm_en_r[g];
            assign cif.hh_thr = hh_r[g];
            assign cif.h_thr = h_r[g];
            assign cif.l_thr = l_r[g];
            assign cif.ll_thr = ll_r[g];
            assign cif.db_out = dbo_r[g];
            assign cif.db_in = dbi_r[g];
            assign cif.tach_en = tach_en_r[g];
            assign cif.trig_rise = trig_r[g];
            assign cif.off_lvl = off_r[g];
            assign cif.on_lvl = on_r[g];
            aatd_chan u_chan (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_sync_r),
                .cfg(cif.eval),
                .reading_i(reading_i[g]),
                .volt_i(tach_volt_i[g]),
                .alarm_o(alarm_w[g]),
                .lvl_o(lvl_w[g]),
                .pulse_o(pulse_w[g])
            );
            assign alarm_hh_o[g] = alarm_w[g][ALM_HH];
            assign alarm_h_o[g] = alarm_w[g][ALM_H];
            assign alarm_l_o[g] = alarm_w[g][ALM_L];
            assign alarm_ll_o[g] = alarm_w[g][ALM_LL];
            assign hi_eng_o[g] = hi_eng_r[g];
        end
    endgenerate

    assign tach_lvl_o = lvl_w;
    assign tach_pulse_o = pulse_w;

    // Both pulse inputs low; both must be in tach mode
    wire logic [NPAIR-1:0] both_low = {
        dual_en_r[1] & tach_en_r[2] & tach_en_r[3] & ~lvl_w[2] & ~lvl_w[3],
        dual_en_r[0] & tach_en_r[0] & tach_en_r[1] & ~lvl_w[0] & ~lvl_w[1]};

    always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            fault_r <= '0;
        end else begin
            fault_r <= both_low;
        end
    end

    assign pair_fault_o = fault_r;

    dual_low_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        dual_en_r[0] && tach_en_r[1:0] == 2'h3 && lvl_w[1:0] == 2'h0
        |=> pair_fault_o[0])
        else $error("pair 0 dual low not flagged");
    dual_off_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        !dual_en_r[1] |=> !pair_fault_o[1])
        else $error("pair 1 fault while disabled");
    fault_mode_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        tach_en_r[1:0] != 2'h3 |=> !pair_fault_o[0])
        else $error("pair 0 fault outside tach mode");
    fault_high_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        lvl_w[1:0] != 2'h0 |=> !pair_fault_o[0])
        else $error("pair 0 fault with one input high");
    dual_share_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_DUAL_EN && !cfg_ch_i[1]
        |=> dual_en_r[0] == $past(wr_bit)
            && dual_en_r[1] == $past(dual_en_r[1]))
        else $error("dual low write missed its pair");
    tach_scale_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_TACH_EN && wr_bit
        |=> hi_eng_o[$past(cfg_ch_i)] == DEF_HI_ENG_TACH)
        else $error("tach mode scaling not reloaded");
    outer_off_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        alm_en_r == 4'h0 |=> alarm_hh_o == 4'h0 && alarm_ll_o == 4'h0)
        else $error("outer alarm raised while disabled");
    thr_write_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_HH_THR
        |=> hh_r[$past(cfg_ch_i)] == $past(cfg_data_i))
        else $error("high-high threshold write lost");
    outer_db_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_DB_OUT
        |=> dbo_r[$past(cfg_ch_i)] == $past(wr_db))
        else $error("outer deadband write lost");
    inner_db_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_DB_IN
        |=> dbi_r[$past(cfg_ch_i)] == $past(wr_db))
        else $error("inner deadband write lost");
    off_write_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_OFF_LVL
        |=> off_r[$past(cfg_ch_i)] == $past(wr_lvl))
        else $error("off level write lost");
    on_write_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        cfg_wr_i && cfg_sel_i == FLD_ON_LVL
        |=> on_r[$past(cfg_ch_i)] == $past(wr_lvl))
        else $error("on level write lost");
    pulse_once_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        tach_pulse_o != 4'h0
        |=> (tach_pulse_o & $past(tach_pulse_o)) == 4'h0)
        else $error("tach pulse longer than one cycle");
    idle_lvl_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_sync_r)
        tach_en_r == 4'h0 |=> tach_lvl_o == 4'hf && tach_pulse_o == 4'h0)
        else $error("tach activity outside tach mode");
endmodule

//--- tb/aatd_cfg_host.sv
`timescale 1ns/10ps
// Configuring party: one field write per call, strobe held one edge
module aatd_cfg_host (
    input wire logic clk_sys_i,
    output logic cfg_wr_o,
    output logic [1:0] cfg_ch_o,
    output logic [3:0] cfg_sel_o,
    output logic [15:0] cfg_data_o
);
    import aatd_pkg::*;
    initial begin
        cfg_wr_o = 1'b0;
        cfg_ch_o = 2'h0;
        cfg_sel_o = 4'hf;
        cfg_data_o = 16'h0000;
    end
    task automatic wr(input logic [1:0] ch, input logic [3:0] sel,
            input logic [15:0] d);
        @(posedge clk_sys_i);
        cfg_wr_o <= 1'b1;
        cfg_ch_o <= ch;
        cfg_sel_o <= sel;
        cfg_data_o <= d;
        @(posedge clk_sys_i);
        cfg_wr_o <= 1'b0;
        // Released data is scrambled so nothing leans on a stale value
        cfg_data_o <= ~d;
        cfg_sel_o <= ~sel;
    endtask
    // Ordered thresholds
    // Low side first, so no transient breaks the ordering on the way
    task automatic thr(input logic [1:0] ch, input logic [15:0] hh, h, l,
            ll);
        wr(ch, FLD_LL_THR, ll);
        wr(ch, FLD_L_THR, l);
        wr(ch, FLD_H_THR, h);
        wr(ch, FLD_HH_THR, hh);
    endtask
    // Pair in tach mode
    // Off level always chosen below on level by the caller
    task automatic tach_pair(input logic p, input logic [4:0] off, on);
        for (int i = 0; i < 2; i++) begin
            wr({p, i[0]}, FLD_TACH_EN, 16'h0001);
            wr({p, i[0]}, FLD_OFF_LVL, {11'h000, off});
            wr({p, i[0]}, FLD_ON_LVL, {11'h000, on});
        end
        wr({p, 1'b0}, FLD_DUAL_EN, 16'h0001);
    endtask
endmodule

//--- tb/analog_alarm_tach_diag_bench.sv
`timescale 1ns/10ps
module analog_alarm_tach_diag_bench;
    import aatd_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_wr;
    logic [1:0] cfg_ch;
    logic [3:0] cfg_sel;
    logic [15:0] cfg_data;
    logic [3:0][DW-1:0] reading = '0;
    logic [3:0][VW-1:0] volt = {4{8'h14}};
    logic [3:0] hh, h, l, ll, lvl, pulse;
    logic [1:0] fault;
    logic [3:0][DW-1:0] hi_eng;
    int bad_count = 0;
    int num_checks = 0;
    aatd_cfg_host host (.clk_sys_i(clk_sys_i), .cfg_wr_o(cfg_wr),
        .cfg_ch_o(cfg_ch), .cfg_sel_o(cfg_sel), .cfg_data_o(cfg_data));
    aatd_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .cfg_wr_i(cfg_wr), .cfg_ch_i(cfg_ch), .cfg_sel_i(cfg_sel),
        .cfg_data_i(cfg_data), .reading_i(reading), .tach_volt_i(volt),
        .alarm_hh_o(hh), .alarm_h_o(h), .alarm_l_o(l), .alarm_ll_o(ll),
        .tach_lvl_o(lvl), .tach_pulse_o(pulse), .pair_fault_o(fault),
        .hi_eng_o(hi_eng));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reading reaches alarms one edge after it is driven
    task automatic rd(input logic [15:0] v);
        @(posedge clk_sys_i);
        reading[0] <= v;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic vt(input int ch, input logic [7:0] v);
        @(posedge clk_sys_i);
        volt[ch] <= v;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic t_defaults();
        chk("hi_eng", DEF_HI_ENG, hi_eng[0]);
        chk("lvl", 16'h000f, {12'h000, lvl});
        rd(16'h7fff);
        // Outer alarms off by default, high threshold 32767
        chk("hh h", 16'h0001, {14'h0000, hh[0], h[0]});
        rd(16'h7ffe);
        chk("h below", 16'h0000, {15'h0000, h[0]});
        rd(16'h0000);
        chk("ll l", 16'h0001, {14'h0000, ll[0], l[0]});
        $display("test defaults done");
    endtask
    task automatic t_alarm();
        host.thr(2'h0, 16'd1000, 16'd500, -16'sd500, -16'sd1000);
        host.wr(2'h0, FLD_DB_OUT, 16'd100);
        host.wr(2'h0, FLD_DB_IN, 16'd50);
        host.wr(2'h0, FLD_ALM_EN, 16'h0001);
        rd(16'd1000);
        chk("hh h set", 16'h0003, {14'h0, hh[0], h[0]});
        rd(16'd900);
        chk("hh held", 16'h0003, {14'h0, hh[0], h[0]});
        rd(16'd899);
        chk("hh clr", 16'h0001, {14'h0, hh[0], h[0]});
        rd(16'd450);
        chk("h held", 16'h0001, {15'h0, h[0]});
        rd(16'd449);
        chk("h clr", 16'h0000, {15'h0, h[0]});
        rd(-16'sd1000);
        chk("ll l set", 16'h0003, {14'h0, ll[0], l[0]});
        rd(-16'sd900);
        chk("ll held", 16'h0003, {14'h0, ll[0], l[0]});
        rd(-16'sd899);
        chk("ll clr", 16'h0001, {14'h0, ll[0], l[0]});
        rd(-16'sd450);
        chk("l held", 16'h0001, {15'h0, l[0]});
        rd(-16'sd449);
        chk("l clr", 16'h0000, {15'h0, l[0]});
        rd(-16'sd1000);
        host.wr(2'h0, FLD_ALM_EN, 16'h0000);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("ll gated", 16'h0001, {14'h0, ll[0], l[0]});
        $display("test alarm done");
    endtask
    task automatic t_tach();
        host.tach_pair(1'b0, 5'd5, 5'd11);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("hi_eng tach", DEF_HI_ENG_TACH, hi_eng[1]);
        chk("lvl on", 16'h0001, {15'h0, lvl[0]});
        vt(0, 8'd6);
        chk("lvl hold hi", 16'h0001, {15'h0, lvl[0]});
        vt(0, 8'd5);
        chk("lvl pulse", 16'h0001, {14'h0, lvl[0], pulse[0]});
        @(posedge clk_sys_i);
        #1;
        chk("pulse once", 16'h0000, {15'h0, pulse[0]});
        vt(0, 8'd10);
        chk("lvl hold lo", 16'h0000, {15'h0, lvl[0]});
        vt(1, 8'd0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("fault", 16'h0001, {14'h0, fault});
        vt(1, 8'd11);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("fault clr", 16'h0000, {14'h0, fault});
        vt(0, 8'd20);
        host.wr(2'h0, FLD_TRIG, 16'h0001);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("inv lvl", 16'h0000, {15'h0, lvl[0]});
        vt(0, 8'd5);
        chk("rise idle", 16'h0002, {14'h0, lvl[0], pulse[0]});
        vt(0, 8'd11);
        chk("rise pulse", 16'h0001, {14'h0, lvl[0], pulse[0]});
        host.wr(2'h1, FLD_HI_ENG, 16'd2000);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("hi_eng wr", 16'd2000, hi_eng[1]);
        $display("test tach done");
    endtask
    // Mid-run reset must bring back the scaling, tach level, fault and alarm enable defaults
    task automatic t_reset();
        host.wr(2'h0, FLD_ALM_EN, 16'h0001);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("ll pre rst", 16'h0003, {14'h0, ll[0], l[0]});
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("hi_eng rst", DEF_HI_ENG, hi_eng[0]);
        chk("lvl rst", 16'h000f, {12'h000, lvl});
        chk("fault rst", 16'h0000, {14'h0, fault});
        chk("ll rst", 16'h0001, {14'h0, ll[0], l[0]});
        $display("test reset done");
    endtask
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        t_defaults();
        t_alarm();
        t_tach();
        t_reset();
        close_out();
    end
endmodule
